// ==== hdl/asp_defines.svh ====
// Constants for the additive sample input port, both ends.
// Assumes both ends run on one 40 MHz system clock; included by bare name.
//
// Contract
// - Device adds external samples into output stream
// - Two 10-bit samples per link clock cycle
// - Samples unsigned binary, bit 9 most significant; the device takes them as offset binary, mid code 10'h200 as zero
// - Source changes sample buses on falling edge; the source also launches a pair mid-low while the link clock idles low
// - Device captures both buses on rising edge
// - Source link clock no faster than 40 MHz
// - Start pulse marks first sample, aligns sequence
// - Device request output paces the source
// - Enable bit gates additive path on/off
`ifndef ASP_DEFINES_SVH
`define ASP_DEFINES_SVH

`define ASP_SAMPLE_W      10
`define ASP_SAMPLE_MSB    9
`define ASP_MIDSCALE      10'h200
`define ASP_EMU_W         16
`define ASP_FIFO_WIDTH    21
`define ASP_FIFO_DEPTH    16
`define ASP_REQ_MARGIN    4
`define ASP_CLK_HZ        40000000
`define ASP_LINK_MAX_HZ   40000000
`define ASP_LINK_DIV_MIN  ((`ASP_CLK_HZ + `ASP_LINK_MAX_HZ - 1) / `ASP_LINK_MAX_HZ)
`define ASP_LINK_DIV      8

`endif

// ==== hdl/asp_pkg.sv ====
// Types for the emulator end of the additive sample input port and its bench.
// Assumes asp_defines.svh for widths.
`include "asp_defines.svh"

package asp_pkg;

	// One captured pair plus its start mark
	typedef struct packed {
		logic                      start;
		logic [`ASP_SAMPLE_W-1:0]  first;
		logic [`ASP_SAMPLE_W-1:0]  second;
	} asp_pair_t;

	// Which sample of the held pair goes out next
	typedef enum logic {
		ASP_SER_FIRST,
		ASP_SER_SECOND
	} asp_ser_t;

endpackage

// ==== hdl/asp_if.sv ====
// Link between the waveform source and the emulator input port.
// Assumes the testbench ties both ends to one instance.
`timescale 1ns/100ps
`include "asp_defines.svh"

interface asp_if;
	logic                      link_clk;
	logic [`ASP_SAMPLE_W-1:0]  first_sample_bus;
	logic [`ASP_SAMPLE_W-1:0]  second_sample_bus;
	logic                      start_pulse;
	logic                      sample_req;

	// Emulator end
	modport dev (
		input  link_clk,
		input  first_sample_bus,
		input  second_sample_bus,
		input  start_pulse,
		output sample_req
	);

	// Waveform source end
	modport src (
		output link_clk,
		output first_sample_bus,
		output second_sample_bus,
		output start_pulse,
		input  sample_req
	);
endinterface

// ==== hdl/asp_device.sv ====
// Emulator end of the additive port: captures pairs off the link, buffers
// them, and adds them one by one into the emulator output stream.
// Assumes clk at 40 MHz and a link clock well below clk/4 so edges are seen.
`timescale 1ns/100ps
`include "asp_defines.svh"

// Plain synchronous FIFO with valid/ready on both sides
module asp_fifo #(
	parameter int WIDTH = `ASP_FIFO_WIDTH,
	parameter int DEPTH = `ASP_FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic                       clk,
	input  wire logic                       reset_n,
	// Fill side
	input  wire logic                       in_valid,
	output logic                            in_ready,
	input  wire logic [WIDTH-1:0]           in_data,
	// Drain side
	output logic                            out_valid,
	input  wire logic                       out_ready,
	output logic [WIDTH-1:0]                out_data,
	// Occupancy
	output logic [$clog2(DEPTH+1)-1:0]      level
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0]            mem [DEPTH];
	logic [AW-1:0]               wr_ptr_r;
	logic [AW-1:0]               rd_ptr_r;
	logic [$clog2(DEPTH+1)-1:0]  count_r;
	logic                        push;
	logic                        pop;

	// Honest flags straight from the count
	assign in_ready  = (count_r != DEPTH[$clog2(DEPTH+1)-1:0]);
	assign out_valid = (count_r != '0);
	assign out_data  = mem[rd_ptr_r];
	assign level     = count_r;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Storage, no reset needed on the array
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_r] <= in_data;
		end
	end

	// Pointers wrap; depth assumed a power of two
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
		end
	end

	// Occupancy count
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			count_r <= '0;
		end else if (push && !pop) begin
			count_r <= count_r + 1'b1;
		end else if (pop && !push) begin
			count_r <= count_r - 1'b1;
		end
	end
endmodule

module asp_device #(
	parameter int FIFO_DEPTH = `ASP_FIFO_DEPTH,
	parameter int REQ_MARGIN = `ASP_REQ_MARGIN,
	parameter int EMU_W      = `ASP_EMU_W
) (
	// Clock and reset
	input  wire logic                     clk,
	input  wire logic                     reset_n,
	// Link to the waveform source
	asp_if.dev                            link,
	// Configuration
	input  wire logic                     additive_enable,
	// Emulator stream in
	input  wire logic                     emu_in_valid,
	input  wire logic signed [EMU_W-1:0]  emu_in_data,
	// Emulator stream out
	output logic                          emu_out_valid,
	output logic signed [EMU_W-1:0]       emu_out_data,
	output logic                          emu_out_start,
	// Status
	output logic                          overflow
);
	localparam int LW = $clog2(FIFO_DEPTH+1);

	// Synchroniser stages for every link pin
	logic                       lclk_s1_r, lclk_s2_r, lclk_d_r;
	asp_pkg::asp_pair_t         pin_s1_r, pin_s2_r;
	logic                       en_s1_r, en_s2_r;
	logic                       rise;
	// FIFO hookup
	logic                       fifo_in_ready;
	logic                       fifo_out_valid;
	logic                       fifo_out_ready;
	asp_pkg::asp_pair_t         fifo_out_data;
	logic [LW-1:0]              fifo_level;
	// Serialiser
	asp_pkg::asp_pair_t         pair_r;
	logic                       have_r;
	asp_pkg::asp_ser_t          ser_r;
	logic                       aligned_r;
	logic                       consume;
	logic                       last_of_pair;
	logic [`ASP_SAMPLE_W-1:0]   ext_code;
	logic signed [EMU_W:0]      ext_val;
	logic signed [EMU_W:0]      sum;
	// Registered outputs
	logic                       req_r;
	logic                       emu_out_valid_r;
	logic signed [EMU_W-1:0]    emu_out_data_r;
	logic                       emu_out_start_r;
	logic                       overflow_r;

	// Two flops on every pin; clock and data share the same delay
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			lclk_s1_r <= 1'b0;
			lclk_s2_r <= 1'b0;
			lclk_d_r  <= 1'b0;
			pin_s1_r  <= '0;
			pin_s2_r  <= '0;
		end else begin
			lclk_s1_r <= link.link_clk;
			lclk_s2_r <= lclk_s1_r;
			lclk_d_r  <= lclk_s2_r;
			pin_s1_r  <= '{start: link.start_pulse,
			               first: link.first_sample_bus,
			               second: link.second_sample_bus};
			pin_s2_r  <= pin_s1_r;
		end
	end

	// Enable may come from another domain, so it is synchronised too
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			en_s1_r <= 1'b0;
			en_s2_r <= 1'b0;
		end else begin
			en_s1_r <= additive_enable;
			en_s2_r <= en_s1_r;
		end
	end

	// Rising link edge: both buses taken together, data settled since the fall or since the launch while idling low
	assign rise = lclk_s2_r && !lclk_d_r;

	asp_fifo #(
		.WIDTH ($bits(asp_pkg::asp_pair_t)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.reset_n   (reset_n),
		.in_valid  (rise),
		.in_ready  (fifo_in_ready),
		.in_data   (pin_s2_r),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_data),
		.level     (fifo_level)
	);

	// A pair arriving with no room is lost; flag it sticky until reset
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			overflow_r <= 1'b0;
		end else if (rise && !fifo_in_ready) begin
			overflow_r <= 1'b1;
		end
	end

	// Ask for pairs only while enabled and with slack for pairs in flight
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			req_r <= 1'b0;
		end else begin
			req_r <= en_s2_r &&
			         (fifo_level <= LW'(FIFO_DEPTH - REQ_MARGIN));
		end
	end

	// Output sample slot uses one external sample when one is held
	assign consume      = emu_in_valid && have_r;
	assign last_of_pair = (ser_r == asp_pkg::ASP_SER_SECOND);
	// Disabled: drain and drop; enabled: refill when empty or pair used up
	assign fifo_out_ready = !en_s2_r || !have_r || (consume && last_of_pair);

	// Pair holder and alignment on the start mark
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pair_r    <= '0;
			have_r    <= 1'b0;
			aligned_r <= 1'b0;
		end else if (!en_s2_r) begin
			have_r    <= 1'b0;
			aligned_r <= 1'b0;
		end else if (fifo_out_ready && fifo_out_valid &&
		             (aligned_r || fifo_out_data.start)) begin
			pair_r    <= fifo_out_data;
			have_r    <= 1'b1;
			aligned_r <= 1'b1;
		end else if (consume && last_of_pair) begin
			have_r    <= 1'b0;
		end
	end

	// Serialiser: first bus sample, then second bus sample
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ser_r <= asp_pkg::ASP_SER_FIRST;
		end else if (!have_r) begin
			ser_r <= asp_pkg::ASP_SER_FIRST;
		end else if (consume) begin
			case (ser_r)
				asp_pkg::ASP_SER_FIRST: begin
					ser_r <= asp_pkg::ASP_SER_SECOND;
				end
				asp_pkg::ASP_SER_SECOND: begin
					ser_r <= asp_pkg::ASP_SER_FIRST;
				end
				default: begin
					ser_r <= asp_pkg::ASP_SER_FIRST;
				end
			endcase
		end
	end

	// Offset binary to signed, mid code as zero; nothing held adds zero
	always_comb begin
		ext_code = last_of_pair ? pair_r.second : pair_r.first;
		if (have_r && en_s2_r) begin
			ext_val = (EMU_W+1)'(signed'({1'b0, ext_code})) -
			          (EMU_W+1)'(signed'({1'b0, `ASP_MIDSCALE}));
		end else begin
			ext_val = '0;
		end
		sum = (EMU_W+1)'(emu_in_data) + ext_val;
	end

	// Saturating adder output stage
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			emu_out_valid_r <= 1'b0;
			emu_out_data_r  <= '0;
			emu_out_start_r <= 1'b0;
		end else begin
			emu_out_valid_r <= emu_in_valid;
			emu_out_start_r <= consume && !last_of_pair && pair_r.start;
			if (emu_in_valid) begin
				if (sum[EMU_W] != sum[EMU_W-1]) begin
					emu_out_data_r <= sum[EMU_W] ? {1'b1, {(EMU_W-1){1'b0}}}
					                             : {1'b0, {(EMU_W-1){1'b1}}};
				end else begin
					emu_out_data_r <= sum[EMU_W-1:0];
				end
			end
		end
	end

	assign link.sample_req = req_r;
	assign emu_out_valid   = emu_out_valid_r;
	assign emu_out_data    = emu_out_data_r;
	assign emu_out_start   = emu_out_start_r;
	assign overflow        = overflow_r;
endmodule

// ==== hdl/asp_source.sv ====
// Waveform source end: divides clk into the link clock, launches each pair
// while the clock is low and holds the clock low while it has nothing to send.
// Assumes clk at 40 MHz; LINK_DIV even and at least 2.
`timescale 1ns/100ps
`include "asp_defines.svh"

module asp_source #(
	parameter int LINK_DIV = `ASP_LINK_DIV
) (
	// Clock and reset
	input  wire logic                      clk,
	input  wire logic                      reset_n,
	// Link to the emulator
	asp_if.src                             link,
	// Waveform feed
	input  wire logic                      wave_valid,
	input  wire logic [`ASP_SAMPLE_W-1:0]  wave_first,
	input  wire logic [`ASP_SAMPLE_W-1:0]  wave_second,
	input  wire logic                      wave_start,
	output logic                           wave_ready
);
	// Never faster than the link allows, never below two clk per period
	localparam int DIV  = (LINK_DIV < 2) ? 2 : LINK_DIV;
	localparam int HALF = DIV / 2;
	localparam int CW   = $clog2(HALF + 1);

	logic                      req_s1_r, req_s2_r;
	logic [CW-1:0]             cnt_r;
	logic                      tick;
	logic                      lclk_r;
	logic                      loaded_r;
	logic                      launch;
	logic [`ASP_SAMPLE_W-1:0]  first_r, second_r;
	logic                      start_r;
	logic                      ready_r;

	// Request crosses in from the far end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			req_s1_r <= 1'b0;
			req_s2_r <= 1'b0;
		end else begin
			req_s1_r <= link.sample_req;
			req_s2_r <= req_s1_r;
		end
	end

	// Half period timer
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_r <= '0;
		end else if (tick) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_r + 1'b1;
		end
	end
	assign tick = (cnt_r == CW'(HALF - 1));

	// New pair only while low (at the fall or idling low) and requested
	assign launch = tick && (lclk_r || !loaded_r) && wave_valid && req_s2_r;

	// Clock: fall after high; rise only when a launched pair waits
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			lclk_r   <= 1'b0;
			loaded_r <= 1'b0;
		end else if (tick) begin
			if (lclk_r) begin
				lclk_r   <= 1'b0;
				loaded_r <= launch;
			end else if (loaded_r) begin
				lclk_r   <= 1'b1;
				loaded_r <= 1'b0;
			end else begin
				loaded_r <= launch;
			end
		end
	end

	// Buses and start change only with the clock low
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			first_r  <= '0;
			second_r <= '0;
			start_r  <= 1'b0;
			ready_r  <= 1'b0;
		end else begin
			ready_r <= launch;
			if (launch) begin
				first_r  <= wave_first;
				second_r <= wave_second;
				start_r  <= wave_start;
			end
		end
	end

	assign link.link_clk          = lclk_r;
	assign link.first_sample_bus  = first_r;
	assign link.second_sample_bus = second_r;
	assign link.start_pulse       = start_r;
	assign wave_ready             = ready_r;
endmodule

// ==== verif/asp_properties.sv ====
// Link-side properties of the additive port, both ends joined.
// Assumes the bench top instantiates it beside the interface.
`timescale 1ns/100ps
`include "asp_defines.svh"

module asp_properties #(
	parameter int LINK_DIV = `ASP_LINK_DIV
) (
	// Clock and reset
	input wire logic                      clk,
	input wire logic                      reset_n,
	// Link
	input wire logic                      link_clk,
	input wire logic [`ASP_SAMPLE_W-1:0]  first_sample_bus,
	input wire logic [`ASP_SAMPLE_W-1:0]  second_sample_bus,
	input wire logic                      start_pulse,
	input wire logic                      sample_req
);
	localparam int HALF  = LINK_DIV / 2;
	localparam int SETUP = HALF - 2;
	localparam int REQ_AGE = LINK_DIV + 4;
	logic [7:0] hi_r;
	logic [7:0] lo_r;
	logic [7:0] chg_r;
	logic [7:0] req_r;

	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	// Link clock run lengths; low side saturates over long idles
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			hi_r <= 8'h00;
			lo_r <= 8'h00;
		end else begin
			hi_r <= link_clk ? hi_r + 8'h01 : 8'h00;
			lo_r <= (link_clk) ? 8'h00 : ((lo_r == 8'hFF) ? lo_r : lo_r + 8'h01);
		end
	end

	// Ages since the last first_sample_bus change and the last request
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			chg_r <= 8'h00;
			req_r <= 8'h00;
		end else begin
			chg_r <= $changed(first_sample_bus) ? 8'h00 : ((chg_r == 8'hFF) ? chg_r : chg_r + 8'h01);
			req_r <= sample_req ? 8'h00 : ((req_r == 8'hFF) ? req_r : req_r + 8'h01);
		end
	end

	hold_high_a: assert property (link_clk |->
		$stable({first_sample_bus, second_sample_bus, start_pulse}))
		else $error("link buses moved while link clock high");
	setup_time_a: assert property ($rose(link_clk) |-> chg_r >= SETUP)
		else $error("buses changed too close to capture edge");
	high_time_a: assert property ($fell(link_clk) |-> hi_r == HALF)
		else $error("link clock high time wrong");
	low_time_a: assert property ($rose(link_clk) |-> lo_r >= HALF)
		else $error("link clock low time too short");
	req_pace_a: assert property ($rose(link_clk) |-> req_r < REQ_AGE)
		else $error("pair sent without request");
	start_launch_a: assert property ($rose(start_pulse) |->
		!link_clk ##[1:LINK_DIV] $rose(link_clk))
		else $error("start pulse not captured in time");
	pair_capture_a: assert property ($changed(second_sample_bus) |->
		!link_clk ##[1:LINK_DIV] $rose(link_clk))
		else $error("new pair not followed by capture edge");
	fall_bound_a: assert property ($rose(link_clk) |-> ##[1:LINK_DIV] $fell(link_clk))
		else $error("link clock stuck high");
endmodule

// ==== verif/additive_sample_input_port_test.sv ====
// Bench for both ends of the additive port joined by one interface.
// Assumes the design files compile first; drives inputs at falling edges.
`timescale 1ns/100ps
`include "asp_defines.svh"

module additive_sample_input_port_test;
	typedef struct packed {
		logic [9:0]  first;
		logic [9:0]  second;
		logic        start;
		logic [15:0] in1;
		logic [15:0] in2;
		logic [15:0] out1;
		logic [15:0] out2;
	} asp_row_t;
	typedef struct packed {
		logic        st;
		logic [15:0] emu;
		logic [15:0] out;
	} asp_exp_t;

	logic                     clk;
	logic                     reset_n;
	logic                     additive_enable;
	logic                     emu_in_valid;
	logic signed [15:0]       emu_in_data;
	logic                     emu_out_valid;
	logic signed [15:0]       emu_out_data;
	logic                     emu_out_start;
	logic                     overflow;
	logic                     wave_valid;
	logic [9:0]               wave_first;
	logic [9:0]               wave_second;
	logic                     wave_start;
	logic                     wave_ready;
	int                       miscompares;
	int                       checked;
	asp_pkg::asp_pair_t       pend_q[$];
	asp_exp_t                 exp_q[$];
	asp_row_t rows[6] = '{
		'{10'h3FF, 10'h000, 1'b1, 16'h0000, 16'h0000, 16'h01FF, 16'hFE00},
		'{10'h200, 10'h201, 1'b0, 16'h1234, 16'hFFFF, 16'h1234, 16'h0000},
		'{10'h3FF, 10'h000, 1'b0, 16'h7FF0, 16'h8005, 16'h7FFF, 16'h8000},
		'{10'h155, 10'h2AA, 1'b1, 16'h0100, 16'hFF00, 16'h0055, 16'hFFAA},
		'{10'h001, 10'h3FE, 1'b0, 16'h8000, 16'h7FFF, 16'h8000, 16'h7FFF},
		'{10'h280, 10'h17F, 1'b0, 16'h0010, 16'h0020, 16'h0090, 16'hFF9F}};

	asp_if asp_if_i ();
	asp_source asp_source_i (.clk(clk), .reset_n(reset_n), .link(asp_if_i),
		.wave_valid(wave_valid), .wave_first(wave_first), .wave_second(wave_second),
		.wave_start(wave_start), .wave_ready(wave_ready));
	asp_device asp_device_i (.clk(clk), .reset_n(reset_n), .link(asp_if_i),
		.additive_enable(additive_enable), .emu_in_valid(emu_in_valid),
		.emu_in_data(emu_in_data), .emu_out_valid(emu_out_valid),
		.emu_out_data(emu_out_data), .emu_out_start(emu_out_start), .overflow(overflow));
	asp_properties asp_properties_i (.clk(clk), .reset_n(reset_n),
		.link_clk(asp_if_i.link_clk), .first_sample_bus(asp_if_i.first_sample_bus),
		.second_sample_bus(asp_if_i.second_sample_bus),
		.start_pulse(asp_if_i.start_pulse), .sample_req(asp_if_i.sample_req));

	// 40 MHz system clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Source feed; a pair stays up until its take is acknowledged
	initial begin
		wave_valid = 1'b0;
		wave_first = 10'h000;
		wave_second = 10'h000;
		wave_start = 1'b0;
		forever begin
			@(negedge clk);
			if (wave_valid && wave_ready)
				void'(pend_q.pop_front());
			wave_valid = (pend_q.size() > 0);
			if (pend_q.size() > 0)
				{wave_start, wave_first, wave_second} = pend_q[0];
		end
	end

	task automatic chk1(input string what, input logic exp, input logic got);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic end_sim;
		$display("comparisons %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Offset binary sample added to the stream, clamped to 16 bits
	function automatic logic [15:0] exp_sum(input logic signed [15:0] a, input logic [9:0] x);
		int s;
		s = int'(a) + int'(x) - 512;
		if (s > 32767)
			s = 32767;
		if (s < -32768)
			s = -32768;
		return s[15:0];
	endfunction

	task automatic push_pair(input logic [9:0] f, input logic [9:0] s, input logic st,
		input logic [15:0] a, input logic [15:0] b, input logic [15:0] oa,
		input logic [15:0] ob);
		pend_q.push_back('{st, f, s});
		exp_q.push_back('{st, a, oa});
		exp_q.push_back('{1'b0, b, ob});
	endtask

	// Unmarked pair whose expected sums come from the offset binary model
	task automatic push_calc(input logic [9:0] f, input logic [9:0] s,
		input logic [15:0] a, input logic [15:0] b);
		push_pair(f, s, 1'b0, a, b, exp_sum(a, f), exp_sum(b, s));
	endtask

	// Bounded wait until the source has handed over every pair
	task automatic wait_fed(input int lim);
		int k;
		k = 0;
		while (pend_q.size() > 0 && k < lim) begin
			@(negedge clk);
			k++;
		end
		if (pend_q.size() > 0) begin
			miscompares++;
			$display("BAD feed expected 0 seen %0d", pend_q.size());
			end_sim;
		end
		repeat (2 * `ASP_LINK_DIV) @(negedge clk);
	endtask

	// Emulator samples with gap idle cycles between them
	task automatic consume(input int n, input int gap);
		asp_exp_t e;
		for (int i = 0; i <= n; i++) begin
			@(negedge clk);
			if (i > 0) begin
				chk1("out_valid", 1'b1, emu_out_valid);
				chk1("out_start", e.st, emu_out_start);
				chk16("out_data", e.out, emu_out_data);
			end
			if (i < n && gap > 0) begin
				emu_in_valid = 1'b0;
				repeat (gap) @(negedge clk);
			end
			if (i < n) begin
				e = exp_q.pop_front();
				emu_in_data = e.emu;
				emu_in_valid = 1'b1;
			end else begin
				emu_in_valid = 1'b0;
			end
		end
	endtask

	// Main sequence
	initial begin
		miscompares = 0;
		checked = 0;
		reset_n = 1'b0;
		additive_enable = 1'b0;
		emu_in_valid = 1'b0;
		emu_in_data = 16'h0000;
		repeat (10) @(negedge clk);
		chk1("sample_req", 1'b0, asp_if_i.sample_req);
		chk1("link_clk", 1'b0, asp_if_i.link_clk);
		chk1("out_valid", 1'b0, emu_out_valid);
		chk1("overflow", 1'b0, overflow);
		reset_n = 1'b1;
		$display("test reset done");
		additive_enable = 1'b1;
		foreach (rows[i])
			push_pair(rows[i].first, rows[i].second, rows[i].start, rows[i].in1,
				rows[i].in2, rows[i].out1, rows[i].out2);
		wait_fed(400);
		consume(12, 0);
		$display("test table done");
		// Fill the buffer with the stream stalled, then drain slowly
		for (int i = 0; i < 16; i++)
			push_calc(10'(i * 61), 10'(1023 - i * 29), 16'(i * 300), 16'(-i * 300));
		repeat (300) @(negedge clk);
		chk1("sample_req", 1'b0, asp_if_i.sample_req);
		chk1("held_back", 1'b1, pend_q.size() > 0);
		consume(32, 12);
		$display("test fill done");
		exp_q.push_back('{1'b0, 16'h1234, 16'h1234});
		consume(1, 0);
		$display("test underrun done");
		// Held pairs are dropped once the path is disabled
		push_pair(10'h3FF, 10'h3FF, 1'b0, 16'h0000, 16'h0000, 16'h01FF, 16'h01FF);
		wait_fed(200);
		additive_enable = 1'b0;
		repeat (8) @(negedge clk);
		chk1("sample_req", 1'b0, asp_if_i.sample_req);
		exp_q.delete();
		exp_q.push_back('{1'b0, 16'h0042, 16'h0042});
		exp_q.push_back('{1'b0, 16'hFFC0, 16'hFFC0});
		consume(2, 0);
		push_pair(10'h300, 10'h100, 1'b1, 16'h0000, 16'h0000, 16'h0100, 16'hFF00);
		repeat (100) @(negedge clk);
		chk1("held_back", 1'b1, pend_q.size() > 0);
		additive_enable = 1'b1;
		wait_fed(200);
		consume(2, 0);
		chk1("overflow", 1'b0, overflow);
		$display("test enable done");
		// Reset in mid-run must drop a held pair and wait for a new start
		push_pair(10'h3FF, 10'h3FF, 1'b0, 16'h0000, 16'h0000, 16'h01FF, 16'h01FF);
		wait_fed(200);
		reset_n = 1'b0;
		exp_q.delete();
		repeat (2) @(negedge clk);
		chk1("sample_req", 1'b0, asp_if_i.sample_req);
		chk1("link_clk", 1'b0, asp_if_i.link_clk);
		chk1("out_valid", 1'b0, emu_out_valid);
		chk1("overflow", 1'b0, overflow);
		reset_n = 1'b1;
		push_pair(10'h3C0, 10'h040, 1'b1, 16'h0000, 16'h0000, 16'h01C0, 16'hFE40);
		wait_fed(200);
		consume(2, 0);
		$display("test midrun reset done");
		end_sim;
	end
endmodule
